// ===== pkg/ssq_pkg.sv
// Purpose: Shared constants for the step/direction microstep sequencer
// Assumes: One system clock; STEP and DIR are synchronous inputs
// Notes: Register map, field layout and interpolator figures live here

package ssq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ANGLE_W = 10;
  localparam int IDX_W = 8;
  localparam int AMP_W = 8;
  localparam int COIL_W = 9;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MICROSTEP_RESOLUTION_W = 4;
  localparam int PERIOD_W = 21;
  localparam int PEND_W = 5;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_COIL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h0C;

  localparam int CTRL_DOUBLE_EDGE_SELECT_BIT = 0;
  localparam int CTRL_INTERP_BIT = 1;
  localparam int CTRL_MICROSTEP_RESOLUTION_LSB = 4;
  localparam logic CTRL_DOUBLE_EDGE_SELECT_RST = 1'b0;
  localparam logic CTRL_INTERP_RST = 1'b0;
  localparam logic [MICROSTEP_RESOLUTION_W-1:0] CTRL_MICROSTEP_RESOLUTION_RST = 4'h0;

  localparam int STATUS_STANDSTILL_FLAG_BIT = 0;
  localparam int STATUS_BUSY_BIT = 1;
  localparam int STATUS_PEND_LSB = 8;
  localparam int STATUS_ANGLE_LSB = 16;
  localparam int COIL_B_LSB = 16;

  // ----------------------------------------------------------------
  // Stepping figures
  // ----------------------------------------------------------------
  localparam logic [MICROSTEP_RESOLUTION_W-1:0] MICROSTEP_RESOLUTION_FULL = 4'h8;
  localparam logic [PEND_W-1:0] INTERP_STEPS = 5'h10;
  localparam int INTERP_SHIFT = 4;
  localparam logic [ANGLE_W-1:0] QUARTER_OFFSET = 10'h100;
  localparam int STANDSTILL_FLAG_CYCLES_DEF = 2 ** 20;

endpackage : ssq_pkg

// ===== rtl/ssq_sine_rom.sv
// Purpose: Quarter-wave sine table with two registered read ports
// Assumes: Index already mirrored by the caller
// Notes: Read data appear one clock after the index

`timescale 1ns/1ps

module ssq_sine_rom
  import ssq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Read ports
  input wire logic [ssq_pkg::IDX_W-1:0] idx_a,
  input wire logic [ssq_pkg::IDX_W-1:0] idx_b,
  output logic [ssq_pkg::AMP_W-1:0] amp_a,
  output logic [ssq_pkg::AMP_W-1:0] amp_b
);

  // ----------------------------------------------------------------
  // Table
  // ----------------------------------------------------------------
  localparam logic [AMP_W-1:0] SINE_TBL [256] = '{
    8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B,
    8'h0D, 8'h0E, 8'h10, 8'h11, 8'h13, 8'h15, 8'h16, 8'h18,
    8'h19, 8'h1B, 8'h1C, 8'h1E, 8'h1F, 8'h21, 8'h22, 8'h24,
    8'h25, 8'h27, 8'h28, 8'h2A, 8'h2B, 8'h2D, 8'h2E, 8'h30,
    8'h31, 8'h33, 8'h34, 8'h36, 8'h37, 8'h39, 8'h3A, 8'h3C,
    8'h3D, 8'h3E, 8'h40, 8'h41, 8'h43, 8'h44, 8'h46, 8'h47,
    8'h49, 8'h4A, 8'h4C, 8'h4D, 8'h4F, 8'h50, 8'h51, 8'h53,
    8'h54, 8'h56, 8'h57, 8'h59, 8'h5A, 8'h5B, 8'h5D, 8'h5E,
    8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h67, 8'h68, 8'h69,
    8'h6B, 8'h6C, 8'h6D, 8'h6F, 8'h70, 8'h72, 8'h73, 8'h74,
    8'h76, 8'h77, 8'h78, 8'h7A, 8'h7B, 8'h7C, 8'h7E, 8'h7F,
    8'h80, 8'h81, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88, 8'h89,
    8'h8A, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h91, 8'h92, 8'h93,
    8'h94, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9C, 8'h9D,
    8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA3, 8'hA4, 8'hA5, 8'hA6,
    8'hA7, 8'hA8, 8'hA9, 8'hAA, 8'hAC, 8'hAD, 8'hAE, 8'hAF,
    8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7,
    8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF,
    8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7,
    8'hC8, 8'hC9, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE,
    8'hCF, 8'hCF, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD4,
    8'hD5, 8'hD6, 8'hD7, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDA,
    8'hDB, 8'hDC, 8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hDF, 8'hE0,
    8'hE1, 8'hE1, 8'hE2, 8'hE2, 8'hE3, 8'hE4, 8'hE4, 8'hE5,
    8'hE5, 8'hE6, 8'hE7, 8'hE7, 8'hE8, 8'hE8, 8'hE9, 8'hE9,
    8'hEA, 8'hEA, 8'hEB, 8'hEB, 8'hEC, 8'hEC, 8'hED, 8'hED,
    8'hEE, 8'hEE, 8'hEE, 8'hEF, 8'hEF, 8'hF0, 8'hF0, 8'hF0,
    8'hF1, 8'hF1, 8'hF1, 8'hF2, 8'hF2, 8'hF2, 8'hF3, 8'hF3,
    8'hF3, 8'hF4, 8'hF4, 8'hF4, 8'hF4, 8'hF5, 8'hF5, 8'hF5,
    8'hF5, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF7, 8'hF7,
    8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF8, 8'hF8,
    8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8
  };

  // ----------------------------------------------------------------
  // Registered read
  // ----------------------------------------------------------------
  logic [AMP_W-1:0] amp_a_next;
  logic [AMP_W-1:0] amp_b_next;

  always_comb begin
    amp_a_next = SINE_TBL[idx_a];
    amp_b_next = SINE_TBL[idx_b];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      amp_a <= '0;
      amp_b <= '0;
    end else begin
      amp_a <= amp_a_next;
      amp_b <= amp_b_next;
    end
  end

endmodule // ssq_sine_rom

// ===== rtl/ssq_sequencer.sv
// Purpose: Step/direction front end, angle counter, interpolator, coil targets
// Assumes: STEP_IN and DIR_IN synchronous; bus strobes one cycle, never both
// Notes: Coil targets lag the angle by two clocks (table read, sign stage)
//
// Local design decisions: the placing of the registers and the strobed register port.

`timescale 1ns/1ps

module ssq_sequencer
  import ssq_pkg::*;
#(
  parameter int STANDSTILL_FLAG_CYCLES = ssq_pkg::STANDSTILL_FLAG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Step interface
  input wire logic STEP_IN,
  input wire logic DIR_IN,
  // Standalone configuration
  input wire logic HALF_STANDBY_IN,
  // Register port
  input wire logic [ssq_pkg::ADDR_W-1:0] BUS_ADDR,
  input wire logic [ssq_pkg::DATA_W-1:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [ssq_pkg::DATA_W-1:0] BUS_RDATA,
  // Coil targets and status
  output logic signed [ssq_pkg::COIL_W-1:0] COIL_A_CURRENT,
  output logic signed [ssq_pkg::COIL_W-1:0] COIL_B_CURRENT,
  output logic [ssq_pkg::ANGLE_W-1:0] ANGLE,
  output logic STANDSTILL
);

  import ssq_pkg::*;

  localparam int IVAL_W = PERIOD_W - INTERP_SHIFT;
  localparam logic [PERIOD_W-1:0] STANDSTILL_FLAG_LIMIT = PERIOD_W'(STANDSTILL_FLAG_CYCLES);
  localparam logic [PERIOD_W-1:0] STANDSTILL_FLAG_LAST = PERIOD_W'(STANDSTILL_FLAG_CYCLES - 1);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  logic step_s1_reg, step_s1_next;
  logic step_s2_reg, step_s2_next;
  logic step_s3_reg, step_s3_next;
  logic dir_s1_reg, dir_s1_next;
  logic dir_s2_reg, dir_s2_next;

  // DIR runs through the same depth as STEP, so its setup to STEP survives
  always_comb begin
    step_s1_next = STEP_IN;
    step_s2_next = step_s1_reg;
    step_s3_next = step_s2_reg;
    dir_s1_next = DIR_IN;
    dir_s2_next = dir_s1_reg;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      step_s1_reg <= 1'b0;
      step_s2_reg <= 1'b0;
      step_s3_reg <= 1'b0;
      dir_s1_reg <= 1'b0;
      dir_s2_reg <= 1'b0;
    end else begin
      step_s1_reg <= step_s1_next;
      step_s2_reg <= step_s2_next;
      step_s3_reg <= step_s3_next;
      dir_s1_reg <= dir_s1_next;
      dir_s2_reg <= dir_s2_next;
    end
  end

  // ----------------------------------------------------------------
  // Control register and read port
  // ----------------------------------------------------------------
  logic double_edge_select_reg, double_edge_select_next;
  logic interp_reg, interp_next;
  logic [MICROSTEP_RESOLUTION_W-1:0] microstep_resolution_reg, microstep_resolution_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  logic [ANGLE_W-1:0] angle_reg, angle_next;
  logic [PEND_W-1:0] pend_reg, pend_next;
  logic pdir_reg, pdir_next;
  logic [PERIOD_W-1:0] per_cnt_reg, per_cnt_next;
  logic [PERIOD_W-1:0] period_reg, period_next;
  logic [IVAL_W-1:0] ival_reg, ival_next;
  logic [IVAL_W-1:0] tick_reg, tick_next;
  logic standstill_flag_reg, standstill_flag_next;
  logic signed [COIL_W-1:0] coil_a_reg, coil_a_next;
  logic signed [COIL_W-1:0] coil_b_reg, coil_b_next;

  always_comb begin
    double_edge_select_next = double_edge_select_reg;
    interp_next = interp_reg;
    microstep_resolution_next = microstep_resolution_reg;
    if (BUS_WR && (BUS_ADDR == ADDR_CTRL)) begin
      double_edge_select_next = BUS_WDATA[CTRL_DOUBLE_EDGE_SELECT_BIT];
      interp_next = BUS_WDATA[CTRL_INTERP_BIT];
      microstep_resolution_next = BUS_WDATA[CTRL_MICROSTEP_RESOLUTION_LSB +: MICROSTEP_RESOLUTION_W];
    end
    // Read data stand for exactly the cycle after the strobe
    rdata_next = '0;
    if (BUS_RD) begin
      unique case (BUS_ADDR)
        ADDR_CTRL: begin
          rdata_next[CTRL_DOUBLE_EDGE_SELECT_BIT] = double_edge_select_reg;
          rdata_next[CTRL_INTERP_BIT] = interp_reg;
          rdata_next[CTRL_MICROSTEP_RESOLUTION_LSB +: MICROSTEP_RESOLUTION_W] = microstep_resolution_reg;
        end
        ADDR_STATUS: begin
          rdata_next[STATUS_STANDSTILL_FLAG_BIT] = standstill_flag_reg;
          rdata_next[STATUS_BUSY_BIT] = (pend_reg != '0);
          rdata_next[STATUS_PEND_LSB +: PEND_W] = pend_reg;
          rdata_next[STATUS_ANGLE_LSB +: ANGLE_W] = angle_reg;
        end
        ADDR_COIL: begin
          rdata_next[0 +: COIL_W] = coil_a_reg;
          rdata_next[COIL_B_LSB +: COIL_W] = coil_b_reg;
        end
        ADDR_PERIOD: begin
          rdata_next[0 +: PERIOD_W] = period_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      double_edge_select_reg <= CTRL_DOUBLE_EDGE_SELECT_RST;
      interp_reg <= CTRL_INTERP_RST;
      microstep_resolution_reg <= CTRL_MICROSTEP_RESOLUTION_RST;
      rdata_reg <= '0;
    end else begin
      double_edge_select_reg <= double_edge_select_next;
      interp_reg <= interp_next;
      microstep_resolution_reg <= microstep_resolution_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Step detection
  // ----------------------------------------------------------------
  logic step_rise;
  logic step_fall;
  logic step_act;
  logic [MICROSTEP_RESOLUTION_W-1:0] microstep_resolution_eff;
  logic [ANGLE_W-1:0] step_inc;

  always_comb begin
    step_rise = step_s2_reg & ~step_s3_reg;
    step_fall = ~step_s2_reg & step_s3_reg;
    step_act = step_rise | (double_edge_select_reg & step_fall);
    // Codes above full step clamp to full step
    microstep_resolution_eff = (microstep_resolution_reg > MICROSTEP_RESOLUTION_FULL) ? MICROSTEP_RESOLUTION_FULL : microstep_resolution_reg;
    step_inc = ANGLE_W'(1) << microstep_resolution_eff;
  end

  // ----------------------------------------------------------------
  // Angle counter, period measurement and interpolator
  // ----------------------------------------------------------------
  logic [PERIOD_W-1:0] period_meas;
  logic [IVAL_W-1:0] ival_eff;
  logic [ANGLE_W-1:0] angle_base;

  always_comb begin
    angle_next = angle_reg;
    pend_next = pend_reg;
    pdir_next = pdir_reg;
    per_cnt_next = per_cnt_reg;
    period_next = period_reg;
    ival_next = ival_reg;
    tick_next = tick_reg;
    standstill_flag_next = standstill_flag_reg;
    // Cycles since the previous active edge, capped at the standstill limit
    period_meas = (per_cnt_reg >= STANDSTILL_FLAG_LIMIT) ? STANDSTILL_FLAG_LIMIT : per_cnt_reg + 1'b1;
    // A period below 16 clocks still gives one microstep per clock
    ival_eff = (ival_reg == '0) ? IVAL_W'(1) : ival_reg;
    // Leftover microsteps of the running step, applied in one jump
    angle_base = pdir_reg ? angle_reg - ANGLE_W'(pend_reg)
                          : angle_reg + ANGLE_W'(pend_reg);

    if (step_act) begin
      per_cnt_next = '0;
      period_next = period_meas;
      standstill_flag_next = 1'b0;
      if (interp_reg) begin
        angle_next = angle_base;
        pend_next = INTERP_STEPS;
        pdir_next = dir_s2_reg;
        ival_next = period_meas[PERIOD_W-1:INTERP_SHIFT];
        tick_next = '0;
      end else begin
        // Leftovers still land so no angle is lost when leaving interpolation
        angle_next = dir_s2_reg ? angle_base - step_inc : angle_base + step_inc;
        pend_next = '0;
      end
    end else begin
      if (per_cnt_reg < STANDSTILL_FLAG_LIMIT) begin
        per_cnt_next = per_cnt_reg + 1'b1;
      end
      if (per_cnt_reg == STANDSTILL_FLAG_LAST) begin
        standstill_flag_next = 1'b1;
      end
      if (pend_reg != '0) begin
        if (tick_reg >= ival_eff - 1'b1) begin
          angle_next = pdir_reg ? angle_reg - 1'b1 : angle_reg + 1'b1;
          pend_next = pend_reg - 1'b1;
          tick_next = '0;
        end else begin
          tick_next = tick_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      angle_reg <= '0;
      pend_reg <= '0;
      pdir_reg <= 1'b0;
      per_cnt_reg <= '0;
      period_reg <= '0;
      ival_reg <= '0;
      tick_reg <= '0;
      standstill_flag_reg <= 1'b0;
    end else begin
      angle_reg <= angle_next;
      pend_reg <= pend_next;
      pdir_reg <= pdir_next;
      per_cnt_reg <= per_cnt_next;
      period_reg <= period_next;
      ival_reg <= ival_next;
      tick_reg <= tick_next;
      standstill_flag_reg <= standstill_flag_next;
    end
  end

  // ----------------------------------------------------------------
  // Sine and cosine lookup
  // ----------------------------------------------------------------
  logic [ANGLE_W-1:0] angle_b;
  logic [IDX_W-1:0] idx_a;
  logic [IDX_W-1:0] idx_b;
  logic [AMP_W-1:0] amp_a;
  logic [AMP_W-1:0] amp_b;
  logic neg_a_reg, neg_a_next;
  logic neg_b_reg, neg_b_next;

  always_comb begin
    angle_b = angle_reg + QUARTER_OFFSET;
    // Odd quadrants read the table backwards, upper half is negative
    idx_a = angle_reg[IDX_W] ? ~angle_reg[IDX_W-1:0] : angle_reg[IDX_W-1:0];
    idx_b = angle_b[IDX_W] ? ~angle_b[IDX_W-1:0] : angle_b[IDX_W-1:0];
    neg_a_next = angle_reg[ANGLE_W-1];
    neg_b_next = angle_b[ANGLE_W-1];
  end

  ssq_sine_rom u_rom (
    .clk(CLK),
    .rst_n(RST_N),
    .idx_a(idx_a),
    .idx_b(idx_b),
    .amp_a(amp_a),
    .amp_b(amp_b)
  );

  // ----------------------------------------------------------------
  // Coil targets
  // ----------------------------------------------------------------
  logic [AMP_W-1:0] mag_a;
  logic [AMP_W-1:0] mag_b;
  logic half_cut;

  always_comb begin
    // Halving by shift rounds odd values down
    half_cut = HALF_STANDBY_IN & standstill_flag_reg;
    mag_a = half_cut ? (amp_a >> 1) : amp_a;
    mag_b = half_cut ? (amp_b >> 1) : amp_b;
    coil_a_next = neg_a_reg ? -$signed({1'b0, mag_a}) : $signed({1'b0, mag_a});
    coil_b_next = neg_b_reg ? -$signed({1'b0, mag_b}) : $signed({1'b0, mag_b});
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      neg_a_reg <= 1'b0;
      neg_b_reg <= 1'b0;
      coil_a_reg <= '0;
      coil_b_reg <= '0;
    end else begin
      neg_a_reg <= neg_a_next;
      neg_b_reg <= neg_b_next;
      coil_a_reg <= coil_a_next;
      coil_b_reg <= coil_b_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign BUS_RDATA = rdata_reg;
  assign COIL_A_CURRENT = coil_a_reg;
  assign COIL_B_CURRENT = coil_b_reg;
  assign ANGLE = angle_reg;
  assign STANDSTILL = standstill_flag_reg;

endmodule // ssq_sequencer

// ===== tb/ssq_sequencer_monitor.sv
// Purpose: Port checks for ssq_sequencer
// Assumes: CTRL is shadowed from bus writes
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
module ssq_sequencer_monitor
  import ssq_pkg::*;
#(
  parameter int STANDSTILL_FLAG_CYCLES = ssq_pkg::STANDSTILL_FLAG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Step side
  input wire logic STEP_IN,
  input wire logic DIR_IN,
  input wire logic HALF_STANDBY_IN,
  // Register port
  input wire logic [ssq_pkg::ADDR_W-1:0] BUS_ADDR,
  input wire logic [ssq_pkg::DATA_W-1:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [ssq_pkg::DATA_W-1:0] BUS_RDATA,
  // Outputs
  input wire logic signed [ssq_pkg::COIL_W-1:0] COIL_A_CURRENT,
  input wire logic signed [ssq_pkg::COIL_W-1:0] COIL_B_CURRENT,
  input wire logic [ssq_pkg::ANGLE_W-1:0] ANGLE,
  input wire logic STANDSTILL
);
  logic [7:0] ctrl_reg, ctrl_next;
  logic [21:0] quiet_reg, quiet_next;
  logic step_d_reg, act;
  // Quiet count restarts on raw pin edges, so it runs ahead of the synchronised one
  always_comb begin
    ctrl_next = ctrl_reg;
    if (BUS_WR && BUS_ADDR == ADDR_CTRL) ctrl_next = BUS_WDATA[7:0] & 8'hF3;
    act = (STEP_IN & ~step_d_reg) | (ctrl_reg[CTRL_DOUBLE_EDGE_SELECT_BIT] & ~STEP_IN & step_d_reg);
    quiet_next = act ? 22'h0 : quiet_reg + {21'h0, ~&quiet_reg};
  end
  always_ff @(posedge CLK) begin
    ctrl_reg <= RST_N ? ctrl_next : 8'h00;
    quiet_reg <= RST_N ? quiet_next : 22'h0;
    step_d_reg <= RST_N ? STEP_IN : 1'b0;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_home;
    (ANGLE == 10'h000 && !HALF_STANDBY_IN)[*3];
  endsequence
  property p_rdata_idle; !BUS_RD |=> BUS_RDATA == 32'h0; endproperty
  property p_ctrl_rd; BUS_RD && BUS_ADDR == ADDR_CTRL |=> BUS_RDATA[7:0] == $past(ctrl_reg);
  endproperty
  property p_status_rd; BUS_RD && BUS_ADDR == ADDR_STATUS |=>
    BUS_RDATA[STATUS_ANGLE_LSB+:ANGLE_W] == $past(ANGLE) && BUS_RDATA[0] == $past(STANDSTILL);
  endproperty
  property p_angle_cause; $changed(ANGLE) && !ctrl_reg[1] && !$past(ctrl_reg[1], 8) |->
    $past(STEP_IN, 3) != $past(STEP_IN, 4) || $past(STEP_IN, 2) != $past(STEP_IN, 3);
  endproperty
  property p_coil_sign; !HALF_STANDBY_IN && $stable(HALF_STANDBY_IN) &&
    !$past(HALF_STANDBY_IN, 2) |-> (COIL_A_CURRENT < 0) == $past(ANGLE[9], 2) &&
    (COIL_B_CURRENT < 0) == ($past(ANGLE[9], 2) ^ $past(ANGLE[8], 2));
  endproperty
  property p_coil_home; s_home |-> COIL_A_CURRENT == 9'sh001 && COIL_B_CURRENT == 9'sh0F8;
  endproperty
  property p_standstill_flag_rise; $rose(STANDSTILL) |-> quiet_reg >= 22'(STANDSTILL_FLAG_CYCLES - 1); endproperty
  property p_standstill_flag_clear; STANDSTILL && act |-> ##[1:5] !STANDSTILL; endproperty
  property p_standstill_flag_hold; STANDSTILL && quiet_reg > 22'h6 |=> STANDSTILL; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
  a_status_rd: assert property (p_status_rd) else $error("status readback wrong");
  a_angle_cause: assert property (p_angle_cause) else $error("angle moved unasked");
  a_coil_sign: assert property (p_coil_sign) else $error("coil sign wrong");
  a_coil_home: assert property (p_coil_home) else $error("home coil values wrong");
  a_standstill_flag_rise: assert property (p_standstill_flag_rise) else $error("standstill too early");
  a_standstill_flag_clear: assert property (p_standstill_flag_clear) else $error("standstill not cleared");
  a_standstill_flag_hold: assert property (p_standstill_flag_hold) else $error("standstill dropped");
endmodule // ssq_sequencer_monitor

bind ssq_sequencer ssq_sequencer_monitor #(.STANDSTILL_FLAG_CYCLES(STANDSTILL_FLAG_CYCLES)) u_mon (
  .CLK(CLK), .RST_N(RST_N), .STEP_IN(STEP_IN), .DIR_IN(DIR_IN),
  .HALF_STANDBY_IN(HALF_STANDBY_IN), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
  .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA), .COIL_A_CURRENT(COIL_A_CURRENT),
  .COIL_B_CURRENT(COIL_B_CURRENT), .ANGLE(ANGLE), .STANDSTILL(STANDSTILL));

// ===== tb/ssq_step_ctrl.sv
// Purpose: Motion controller model on the step pins
// Assumes: Tasks are called from the bench
// Notes: Pins change just after a rising edge only
`timescale 1ns/1ps
module ssq_step_ctrl (
  // Clock
  input wire logic clk,
  // Pins
  output logic step,
  output logic dir,
  output logic half_stby
);
  initial begin
    step = 1'b0;
    dir = 1'b0;
    half_stby = 1'b0;
  end
  // Rise-to-rise spacing is hi+lo+2 clocks; DIR set a clock ahead and held
  task automatic pulse(input logic d, input int hi, input int lo);
    @(posedge clk) dir <= d;
    @(posedge clk) step <= 1'b1;
    repeat (hi) @(posedge clk);
    step <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask
  // One edge either way, for double-edge mode
  task automatic toggle(input logic d);
    @(posedge clk) dir <= d;
    @(posedge clk) step <= ~step;
    repeat (6) @(posedge clk);
  endtask
  task automatic set_half(input logic v);
    @(posedge clk) half_stby <= v;
  endtask
endmodule // ssq_step_ctrl

// ===== tb/ssq_sequencer_tb.sv
// Purpose: Self-checking bench for ssq_sequencer
// Assumes: Standstill span shortened to 64 clocks
// Notes: Coil values checked only where the table entry is known here
`timescale 1ns/1ps
module ssq_sequencer_tb;
  import ssq_pkg::*;
  localparam int STANDSTILL_FLAG = 64;
  logic clk = 1'b0;
  logic rst_n, step, dir, half, wr, rd, standstill_flag;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rv;
  logic signed [COIL_W-1:0] coil_a, coil_b;
  logic [ANGLE_W-1:0] angle;
  logic [31:0] rnd = 32'hE2345064;
  int n_mismatch = 0;
  int compares = 0;
  int ang = 0;
  int m;
  always #4 clk = ~clk;
  ssq_sequencer #(.STANDSTILL_FLAG_CYCLES(STANDSTILL_FLAG)) u_ssq_sequencer (.CLK(clk), .RST_N(rst_n),
    .STEP_IN(step), .DIR_IN(dir), .HALF_STANDBY_IN(half), .BUS_ADDR(addr),
    .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata),
    .COIL_A_CURRENT(coil_a), .COIL_B_CURRENT(coil_b), .ANGLE(angle), .STANDSTILL(standstill_flag));
  ssq_step_ctrl u_ssq_step_ctrl (.clk(clk), .step(step), .dir(dir), .half_stby(half));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int sine(input int a);
    int i, v;
    i = (a & 256) != 0 ? 255 - (a & 255) : a & 255;
    case (i)
      0: v = 1;
      127: v = 175;
      128: v = 176;
      255: v = 248;
      default: return 999;
    endcase
    return (a & 512) != 0 ? -v : v;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pos();
    int e;
    #1 chk("angle", 32'(ang), 32'(angle));
    e = sine(ang);
    if (e != 999) chk("coil_a", 32'(e), 32'(coil_a));
    e = sine(ang + 256);
    if (e != 999) chk("coil_b", 32'(e), 32'(coil_b));
  endtask
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic do_step(input logic d, input int inc, input int hi);
    u_ssq_step_ctrl.pulse(d, hi, 6);
    ang = (d ? ang - inc : ang + inc) & 1023;
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("ERROR watchdog expected done seen timeout");
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // ----------------------------------------
    // Registers, unmapped and read-only places
    // ----------------------------------------
    bus_rd(ADDR_CTRL);
    chk("ctrl_rst", 32'h0, rv);
    bus_wr(ADDR_CTRL, 32'hFFFFFFFF);
    bus_rd(ADDR_CTRL);
    chk("ctrl_rw", 32'h000000F3, rv);
    bus_wr(ADDR_STATUS, 32'hFFFFFFFF);
    bus_rd(8'h10);
    chk("unmapped", 32'h0, rv);
    bus_rd(ADDR_STATUS);
    chk("status_angle", 32'h0, {22'h0, rv[STATUS_ANGLE_LSB+:ANGLE_W]});
    $display("test registers done");
    // ----------------------------------------
    // Every resolution, random direction and width
    // ----------------------------------------
    for (int i = 0; i < 10; i++) begin
      m = (i == 9) ? 15 : 8 - i;
      bus_wr(ADDR_CTRL, 32'(m) << CTRL_MICROSTEP_RESOLUTION_LSB);
      for (int k = 0; k < 3; k++) begin
        rnd = lfsr(rnd);
        do_step(rnd[0], 1 << ((m > 8) ? 8 : m), 1 + int'(rnd[2:1]));
        chk_pos();
      end
    end
    bus_wr(ADDR_CTRL, 32'h00000041);
    for (int k = 0; k < 4; k++) begin
      u_ssq_step_ctrl.toggle(1'b0);
      ang = (ang + 16) & 1023;
      chk_pos();
    end
    $display("test stepping done");
    // ----------------------------------------
    // Standstill and half standby after a second reset
    // ----------------------------------------
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    ang = 0;
    repeat (STANDSTILL_FLAG + 8) @(posedge clk);
    #1 chk("standstill", 32'h1, 32'(standstill_flag));
    u_ssq_step_ctrl.set_half(1'b1);
    repeat (4) @(posedge clk);
    #1 chk("half_a", 32'h0, 32'(coil_a));
    chk("half_b", 32'd124, 32'(coil_b));
    u_ssq_step_ctrl.set_half(1'b0);
    repeat (4) @(posedge clk);
    chk_pos();
    bus_rd(ADDR_COIL);
    chk("coil_reg", 32'h00F80001, rv);
    $display("test standstill done");
    // ----------------------------------------
    // Interpolation
    // ----------------------------------------
    bus_wr(ADDR_CTRL, 32'h00000002);
    u_ssq_step_ctrl.pulse(1'b0, 3, 6);
    #1 chk("standstill_flag_clear", 32'h0, 32'(standstill_flag));
    u_ssq_step_ctrl.pulse(1'b0, 4, 4);
    #1 chk("leftover", 32'h1, 32'(angle >= 10'd16));
    repeat (4) u_ssq_step_ctrl.pulse(1'b0, 15, 15);
    bus_rd(ADDR_PERIOD);
    chk("period", 32'd32, {11'h0, rv[20:0]});
    repeat (80) @(posedge clk);
    ang = 96;
    chk_pos();
    bus_wr(ADDR_CTRL, 32'h0);
    do_step(1'b1, 1, 3);
    chk_pos();
    $display("test interpolation done");
    summarize();
  end
endmodule // ssq_sequencer_tb
